// ===== logic/occ_osc_config.sv
// module: oscillator configuration and pll lock status registers
// assumes a single-cycle strobe register port on clk; lock and the
// analog clock arrive asynchronously from the analog blocks
`timescale 1ns/1ps
// Functional notes
// - read-only lock word, bit 0 lock
// - bypass feeds pll input from pin
// - band bit selects low or high range
// - slow output is analog over 2(1+div)
// - four-bit rate code drives analog frequency
module occ_osc_config (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [occ_pkg::ADDR_W-1:0] addr,
    input  wire logic [occ_pkg::DATA_W-1:0] wrData,
    input  wire logic                  wrStrobe,
    input  wire logic                  rdStrobe,
    output logic      [occ_pkg::DATA_W-1:0] rdData,
    input  wire logic                  pllLocked,
    input  wire logic                  ext_clock_pin,
    input  wire logic                  crystalOscClk,
    input  wire logic                  slowOscAnaClk,
    output logic                       pllInClk,
    output logic                       osc_band_select,
    output logic [occ_pkg::RATE_W-1:0] slow_osc_rate_code,
    output logic                       slowOscClk,
    output logic                       slowOscConfigured,
    output logic                       irq
);
    import occ_pkg::*;
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [1:0]       crystalCfg;
    logic [8:0]       slowCfg;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqMask;
    logic [2:0]       lockSync;
    logic [2:0]       anaSync;
    logic             lockLevel;
    logic             anaLevel;
    logic             configuredPrev;
    logic             lockPrev;
    occ_div_if        divBus ();
    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    wire selLock    = (addr == PLL_LOCK_STATE);
    wire selCrystal = (addr == CRYSTAL_OSC);
    wire selSlow    = (addr == SLOW_OSC);
    wire selStatus  = (addr == IRQ_STATUS);
    wire selMask    = (addr == IRQ_MASK);
    wire selOscStat = (addr == OSC_STATUS);
    wire wrCrystal  = wrStrobe & selCrystal;
    wire wrSlow     = wrStrobe & selSlow;
    wire wrStatus   = wrStrobe & selStatus;
    wire wrMask     = wrStrobe & selMask;
    wire [RATE_W-1:0] rateCode   = slowCfg[RATE_LSB +: RATE_W];
    wire              configured = (rateCode != 4'h0);
    wire [IRQ_W-1:0]  events;
    // lock events from the filtered level, so a metastable flop never fires one
    assign events[EV_LOCK_GAIN]  = lockLevel & ~lockPrev;
    assign events[EV_LOCK_LOSS]  = ~lockLevel & lockPrev;
    assign events[EV_CONFIGURED] = configured & ~configuredPrev;
    wire [IRQ_W-1:0]  clearBits = wrStatus ? wrData[IRQ_W-1:0] : 3'h0;
    wire [DATA_W-1:0] readMux =
        selLock    ? {31'h0000_0000, lockLevel}                     :
        selCrystal ? {30'h0000_0000, crystalCfg}                    :
        selSlow    ? {23'h00_0000, slowCfg}                         :
        selStatus  ? {29'h0000_0000, irqStatus}                     :
        selMask    ? {29'h0000_0000, irqMask}                       :
        selOscStat ? {31'h0000_0000, configured}                    :
                     32'h0000_0000;
    // -------------------------------------------------------------
    // synchronisers: change taken when 2nd and 3rd flops agree
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            lockSync  <= 3'h0;
            anaSync   <= 3'h0;
            lockLevel <= 1'b0;
            anaLevel  <= 1'b0;
        end else begin
            lockSync  <= {lockSync[1:0], pllLocked};
            anaSync   <= {anaSync[1:0], slowOscAnaClk};
            lockLevel <= (lockSync[2] == lockSync[1]) ? lockSync[2] : lockLevel;
            anaLevel  <= (anaSync[2] == anaSync[1]) ? anaSync[2] : anaLevel;
        end
    end
    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            crystalCfg     <= CRYSTAL_RESET;
            slowCfg        <= SLOW_RESET;
            irqMask        <= IRQ_RESET;
            configuredPrev <= 1'b0;
            lockPrev       <= 1'b0;
        end else begin
            lockPrev       <= lockLevel;
            crystalCfg     <= wrCrystal ? wrData[1:0] : crystalCfg;
            slowCfg        <= wrSlow ? wrData[8:0] : slowCfg;
            irqMask        <= wrMask ? wrData[IRQ_W-1:0] : irqMask;
            configuredPrev <= configured;
        end
    end
    // set wins over a simultaneous write-one clear
    always_ff @(posedge clk) begin
        if (reset) begin
            irqStatus <= IRQ_RESET;
            rdData    <= 32'h0000_0000;
        end else begin
            irqStatus <= (irqStatus & ~clearBits) | events;
            rdData    <= rdStrobe ? readMux : 32'h0000_0000;
        end
    end
    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    // clock mux is glitch-prone; change bypass only while pll is unused
    assign pllInClk           = crystalCfg[BYPASS_BIT] ? ext_clock_pin : crystalOscClk;
    assign osc_band_select    = crystalCfg[BAND_BIT];
    assign slow_osc_rate_code = rateCode;
    assign slowOscConfigured  = configured;
    assign irq                = |(irqStatus & irqMask);
    // divider held quiet until rate programmed, as software must do first
    assign divBus.postDivide  = slowCfg[DIV_LSB +: DIV_W];
    assign divBus.enable      = configured;
    assign divBus.anaClkLevel = anaLevel;
    assign slowOscClk         = divBus.outClk;
    occ_post_divider u_div (
        .clk   (clk),
        .reset (reset),
        .dv    (divBus.div)
    );
endmodule : occ_osc_config

// ===== logic/occ_pkg.sv
// package: offsets, field positions and reset values of the
// oscillator configuration and pll lock status registers
// assumes a 32-bit byte-addressed register port
package occ_pkg;
    localparam int          ADDR_W         = 32;
    localparam int          DATA_W         = 32;
    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [31:0] PLL_LOCK_STATE = 32'h4004_800C;
    localparam logic [31:0] CRYSTAL_OSC    = 32'h4004_8020;
    localparam logic [31:0] SLOW_OSC       = 32'h4004_8024;
    localparam logic [31:0] IRQ_STATUS     = 32'h4004_8100;
    localparam logic [31:0] IRQ_MASK       = 32'h4004_8104;
    localparam logic [31:0] OSC_STATUS     = 32'h4004_8108;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int          LOCK_BIT       = 0;
    localparam int          BYPASS_BIT     = 0;
    localparam int          BAND_BIT       = 1;
    localparam int          DIV_LSB        = 0;
    localparam int          DIV_W          = 5;
    localparam int          RATE_LSB       = 5;
    localparam int          RATE_W         = 4;
    localparam int          CONFIGURED_BIT = 0;
    localparam int          IRQ_W          = 3;
    localparam int          EV_LOCK_GAIN   = 0;
    localparam int          EV_LOCK_LOSS   = 1;
    localparam int          EV_CONFIGURED  = 2;
    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [1:0]  CRYSTAL_RESET  = 2'h0;
    localparam logic [8:0]  SLOW_RESET     = 9'h000;
    localparam logic [2:0]  IRQ_RESET      = 3'h0;
    localparam logic [4:0]  DIV_COUNT_RST  = 5'h00;
endpackage : occ_pkg

// ===== logic/occ_div_if.sv
// interface: signals between the register block and the post-divider
// assumes both ends run on the same clk
`timescale 1ns/1ps
interface occ_div_if;
    import occ_pkg::*;
    logic [DIV_W-1:0] postDivide;
    logic             enable;
    logic             anaClkLevel;
    logic             outClk;
    modport ctrl (output postDivide, output enable, output anaClkLevel, input outClk);
    modport div  (input postDivide, input enable, input anaClkLevel, output outClk);
endinterface : occ_div_if

// ===== logic/occ_post_divider.sv
// module: digital post-divider of the low-power oscillator
// assumes anaClkLevel is already synchronised to clk
`timescale 1ns/1ps
module occ_post_divider (
    input  wire logic  clk,
    input  wire logic  reset,
    occ_div_if.div     dv
);
    import occ_pkg::*;
    logic             prevLevel;
    logic [DIV_W-1:0] edgeCount;
    logic             outClk;
    wire              anaRise = dv.anaClkLevel & ~prevLevel;
    // compare with >= so a smaller divide written mid-count takes at once
    wire              lastEdge = (edgeCount >= dv.postDivide);
    // -------------------------------------------------------------
    // toggle every 1+div rising edges: ratio 2*(1+div)
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset || !dv.enable) begin
            prevLevel <= 1'b0;
            edgeCount <= DIV_COUNT_RST;
            outClk    <= 1'b0;
        end else begin
            prevLevel <= dv.anaClkLevel;
            if (anaRise) begin
                edgeCount <= lastEdge ? DIV_COUNT_RST : edgeCount + 5'h01;
                outClk    <= lastEdge ? ~outClk : outClk;
            end
        end
    end
    assign dv.outClk = outClk;
endmodule : occ_post_divider

// ===== bench/occ_osc_config_properties.sv
// checker: port timing of the oscillator configuration registers
// assumes bind onto occ_osc_config, one clock domain
`timescale 1ns/1ps
module occ_osc_config_properties (
    input wire logic                         clk,
    input wire logic                         reset,
    input wire logic [occ_pkg::ADDR_W-1:0]   addr,
    input wire logic [occ_pkg::DATA_W-1:0]   wrData,
    input wire logic                         wrStrobe,
    input wire logic                         rdStrobe,
    input wire logic [occ_pkg::DATA_W-1:0]   rdData,
    input wire logic                         ext_clock_pin,
    input wire logic                         pllInClk,
    input wire logic                         osc_band_select,
    input wire logic [occ_pkg::RATE_W-1:0]   slow_osc_rate_code,
    input wire logic                         slowOscClk,
    input wire logic                         slowOscConfigured
);
    import occ_pkg::*;
    // --------------------------------------------------
    // properties
    // --------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_rdLock; rdStrobe && addr == PLL_LOCK_STATE; endsequence
    sequence s_wrXtal; wrStrobe && addr == CRYSTAL_OSC; endsequence
    sequence s_wrSlow; wrStrobe && addr == SLOW_OSC; endsequence
    a_read_idle: assert property (!rdStrobe |=> rdData == '0)
        else $error("read data not zero outside a read");
    a_lock_reserved: assert property (s_rdLock |=> rdData[31:1] == '0)
        else $error("lock word reserved bits set");
    a_bypass_route: assert property (s_wrXtal ##0 wrData[0] |=> pllInClk == ext_clock_pin)
        else $error("bypass does not route pin");
    a_band_follow: assert property (s_wrXtal |=> osc_band_select == $past(wrData[1]))
        else $error("band bit not taken");
    a_rate_follow: assert property (s_wrSlow |=> slow_osc_rate_code == $past(wrData[8:5]))
        else $error("rate code not taken");
    a_rate_hold: assert property (!wrStrobe |=> $stable(slow_osc_rate_code))
        else $error("rate code moved without write");
    a_config_flag: assert property (slowOscConfigured == (slow_osc_rate_code != 0))
        else $error("configured flag wrong");
    a_div_parked: assert property ((slow_osc_rate_code == 0) [*2] |-> !slowOscClk)
        else $error("divider runs while unconfigured");
endmodule : occ_osc_config_properties
bind occ_osc_config occ_osc_config_properties u_props (.clk(clk), .reset(reset), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .ext_clock_pin(ext_clock_pin), .pllInClk(pllInClk), .osc_band_select(osc_band_select),
    .slow_osc_rate_code(slow_osc_rate_code), .slowOscClk(slowOscClk),
    .slowOscConfigured(slowOscConfigured));

// ===== bench/tb_occ_osc_config.sv
// testbench: register reads, lock word, oscillator muxing, divider, irq
// assumes strobe register port, analog clocks made here from clk
`timescale 1ns/1ps
module tb_occ_osc_config;
    import occ_pkg::*;
    logic clk = 0, reset = 1, wrStrobe = 0, rdStrobe = 0, pllLocked = 0;
    logic ext_clock_pin = 0, crystalOscClk = 0, slowOscAnaClk = 0;
    logic [31:0] addr = 0, wrData = 0, rdData, got, seed = 32'd80558, cycles = 0;
    logic pllInClk, osc_band_select, slowOscClk, slowOscConfigured, irq, prevClk;
    logic [3:0] slow_osc_rate_code, rate, tick = 0;
    logic [4:0] div;
    int num_errors = 0, checks = 0, rises;
    logic [31:0] regList [7] = '{PLL_LOCK_STATE, CRYSTAL_OSC, SLOW_OSC, IRQ_STATUS,
                                 IRQ_MASK, OSC_STATUS, 32'h4004_8000};
    occ_osc_config dut (.clk(clk), .reset(reset), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .pllLocked(pllLocked),
        .ext_clock_pin(ext_clock_pin), .crystalOscClk(crystalOscClk),
        .slowOscAnaClk(slowOscAnaClk), .pllInClk(pllInClk), .osc_band_select(osc_band_select),
        .slow_osc_rate_code(slow_osc_rate_code), .slowOscClk(slowOscClk),
        .slowOscConfigured(slowOscConfigured), .irq(irq));
    always #2.5 clk = ~clk;
    // analog clock: 4 high, 4 low, slow enough for the synchroniser
    always @(posedge clk) begin
        tick <= tick + 1;
        slowOscAnaClk <= tick[2];
        ext_clock_pin <= tick[0];
        crystalOscClk <= ~tick[1];
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            test_done();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        addr <= a; wrData <= d; wrStrobe <= 1;
        @(posedge clk) wrStrobe <= 0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [31:0] a);
        addr <= a; rdStrobe <= 1;
        @(posedge clk) rdStrobe <= 0;
        #1 got = rdData;
        @(posedge clk);
    endtask : rd
    task automatic test_done();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // --------------------------------------------------
    // main sequence
    // --------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        wr(PLL_LOCK_STATE, 32'hFFFF_FFFF);
        foreach (regList[i]) begin
            rd(regList[i]);
            chk(got, 32'h0);
        end
        pllLocked <= 1;
        repeat (8) @(posedge clk);
        rd(PLL_LOCK_STATE); chk(got, 32'h1);
        rd(IRQ_STATUS); chk(got, 32'h1);
        chk(irq, 1'b0);
        wr(IRQ_MASK, 32'h1); chk(irq, 1'b1);
        wr(IRQ_STATUS, 32'h1); chk(irq, 1'b0);
        pllLocked <= 0;
        repeat (8) @(posedge clk);
        rd(PLL_LOCK_STATE); chk(got, 32'h0);
        wr(CRYSTAL_OSC, 32'h3); #1 chk(pllInClk, ext_clock_pin);
        chk(osc_band_select, 1'b1);
        wr(CRYSTAL_OSC, 32'hFFFF_FFFC); #1 chk(pllInClk, crystalOscClk);
        chk(osc_band_select, 1'b0);
        rd(CRYSTAL_OSC); chk(got, 32'h0);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            div = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : seed[4:0];
            rate = (seed[8:5] == 0) ? 4'hF : seed[8:5];
            wr(SLOW_OSC, {seed[31:9], rate, div});
            chk(slow_osc_rate_code, rate); chk(slowOscConfigured, 1'b1);
            rd(SLOW_OSC); chk(got, {23'h0, rate, div});
            rises = 0;
            prevClk = slowOscClk;
            repeat (2048) @(posedge clk) begin
                #1 rises += (slowOscClk && !prevClk);
                prevClk = slowOscClk;
            end
            chk(rises >= 256 / (2 * (div + 1)) - 1 && rises <= 256 / (2 * (div + 1)) + 1, 1);
        end
        wr(SLOW_OSC, 32'h0); rd(OSC_STATUS); chk(got, 32'h0);
        test_done();
    end
endmodule : tb_occ_osc_config
